// ===== rtl/pic_counter.v
// Programmable interval counter channel with AHB-Lite registers
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "pic_defines.vh"
module pic_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Counter pins
  input  wire        cnt_clk,
  input  wire        gate,
  output wire        cnt_out
);
  localparam ST_IDLE = 2'b00;
  localparam ST_LOAD = 2'b01;
  localparam ST_RUN  = 2'b10;
  localparam ST_DONE = 2'b11;

  reg  [2:0]       mode_q;
  reg              bcd_q;
  reg  [WIDTH-1:0] reload_q;
  reg  [WIDTH-1:0] count_q;
  reg  [WIDTH-1:0] latch_q;
  reg  [1:0]       state_q;
  reg              out_q;
  reg              half_q;
  reg              cclk_q;
  reg              gate_q;
  reg              trig_q;
  reg  [31:0]      rdata_q;
  reg              wr_pend_q;
  reg  [3:0]       addr_q;
  reg              range_err_q;
  wire [WIDTH-1:0] dec_val;
  wire             tick;
  wire             gate_rise;
  wire             at_tc;
  wire             at_one;
  wire             acc;
  wire [3:0]       aidx;
  wire [2:0]       wcode;
  wire             wr_ctrl;
  wire             wr_count;

  // Register hit: aligned word inside the four-word window
  function reg_hit;
    input [31:0] a;
    begin
      reg_hit = a[31:`PIC_ADDR_MSB+1] == {(31-`PIC_ADDR_MSB){1'b0}}
                && a[1:0] == 2'b00;
    end
  endfunction

  // Modes whose count starts on a gate trigger
  function gate_started;
    input [2:0] m;
    begin
      gate_started = m == `PIC_CODE_M1 || m == `PIC_CODE_M5;
    end
  endfunction

  // Modes that end with a one-clock strobe
  function strobe_mode;
    input [2:0] m;
    begin
      strobe_mode = m == `PIC_CODE_M4 || m == `PIC_CODE_M5;
    end
  endfunction

  // Periodic modes that refuse a count of one
  function periodic_mode;
    input [2:0] m;
    begin
      periodic_mode = m == `PIC_CODE_M2 || m == `PIC_CODE_M3;
    end
  endfunction

  // Count-value validity for a mode and coding
  function valid_count;
    input [2:0]       m;
    input             b;
    input [WIDTH-1:0] v;
    reg               ok;
    integer           j;
    begin
      ok = 1'b1;
      if (b) begin
        for (j = 0; j < WIDTH / 4; j = j + 1) begin
          if (v[j*4 +: 4] > 4'h9) begin
            ok = 1'b0;
          end
        end
      end
      if (periodic_mode(m) && v == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        ok = 1'b0;
      end
      valid_count = ok;
    end
  endfunction

  assign acc       = hsel && hready && htrans == `PIC_HTRANS_NSEQ;
  assign aidx      = addr_q;
  assign wcode     = hwdata[`PIC_CODE_MSB:`PIC_CODE_LSB];
  assign wr_ctrl   = wr_pend_q && aidx == `PIC_ADDR_CTRL;
  assign wr_count  = wr_pend_q && aidx == `PIC_ADDR_COUNT;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign cnt_out   = out_q;

  // Counter clock advances on its falling edge
  assign tick      = cclk_q && !cnt_clk;
  assign gate_rise = gate && !gate_q;
  assign at_tc     = count_q == {WIDTH{1'b0}};
  assign at_one    = count_q == {{(WIDTH-1){1'b0}}, 1'b1};

  pic_decrement #(
    .WIDTH (WIDTH)
  ) u_dec (
    .value  (count_q),
    .bcd    (bcd_q),
    .by_two (mode_q == `PIC_CODE_M3),
    .result (dec_val)
  );

  always @(posedge core_clk) begin
    if (rst) begin
      cclk_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      cclk_q <= cnt_clk;
      gate_q <= gate;
    end
  end

  // Bus address phase capture
  always @(posedge core_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 4'h0;
    end else begin
      // Unmapped offsets must not alias onto the registers
      wr_pend_q <= acc && hwrite && reg_hit(haddr);
      if (acc) begin
        addr_q <= haddr[`PIC_ADDR_MSB:0];
      end
    end
  end

  // Read data, available one cycle after address phase
  always @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc && !hwrite && !reg_hit(haddr)) begin
      // Unmapped or unaligned offsets read as zero
      rdata_q <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      case (haddr[`PIC_ADDR_MSB:0])
        `PIC_ADDR_CTRL:   rdata_q <= {27'h0, 1'b0, bcd_q, 3'h0} | {29'h0, mode_q};
        `PIC_ADDR_COUNT:  rdata_q <= {{(32-WIDTH){1'b0}}, reload_q};
        `PIC_ADDR_READ:   rdata_q <= {{(32-WIDTH){1'b0}}, latch_q};
        `PIC_ADDR_STATUS: rdata_q <= {28'h0, range_err_q, state_q, out_q};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Mode, coding and count registers
  always @(posedge core_clk) begin
    if (rst) begin
      mode_q      <= `PIC_CODE_M0;
      bcd_q       <= 1'b0;
      reload_q    <= {WIDTH{1'b0}};
      latch_q     <= {WIDTH{1'b0}};
      range_err_q <= 1'b0;
    end else begin
      if (wr_ctrl && wcode != `PIC_CODE_READ && wcode != `PIC_CODE_RESET) begin
        mode_q <= wcode;
        bcd_q  <= hwdata[`PIC_BCD_BIT];
      end
      if (wr_ctrl && wcode == `PIC_CODE_READ) begin
        latch_q <= count_q;
      end
      // value one rejected in modes 2, 3
      if (wr_count) begin
        if (valid_count(mode_q, bcd_q, hwdata[WIDTH-1:0])) begin
          reload_q    <= hwdata[WIDTH-1:0];
          range_err_q <= 1'b0;
        end else begin
          range_err_q <= 1'b1;
        end
      end
    end
  end

  // Counting engine
  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      count_q <= {WIDTH{1'b0}};
      out_q   <= 1'b0;
      half_q  <= 1'b0;
      trig_q  <= 1'b0;
    end else if (wr_ctrl && wcode == `PIC_CODE_RESET) begin
      state_q <= ST_IDLE;
      out_q   <= hwdata[`PIC_LEVEL_BIT];
      trig_q  <= 1'b0;
    end else if (wr_ctrl && wcode != `PIC_CODE_READ) begin
      state_q <= ST_IDLE;
      trig_q  <= 1'b0;
      half_q  <= 1'b0;
      // mode 0 output low on write
      out_q   <= wcode != `PIC_CODE_M0;
    end else if (wr_count && valid_count(mode_q, bcd_q, hwdata[WIDTH-1:0])) begin
      state_q <= ST_LOAD;
      trig_q  <= 1'b0;
      if (mode_q == `PIC_CODE_M0) begin
        out_q <= 1'b0;
      end
    end else begin
      if (gate_started(mode_q) && gate_rise && state_q != ST_IDLE) begin
        trig_q <= 1'b1;
      end
      if (tick) begin
        case (state_q)
          ST_LOAD: begin
            if (gate_started(mode_q)) begin
              // modes 1, 5 wait for gate trigger
              if (trig_q || gate_rise) begin
                trig_q  <= 1'b0;
                count_q <= reload_q;
                state_q <= ST_RUN;
                if (mode_q == `PIC_CODE_M1) begin
                  out_q <= 1'b0;
                end
              end
            end else begin
              count_q <= reload_q;
              state_q <= ST_RUN;
              half_q  <= 1'b0;
              if (mode_q != `PIC_CODE_M0) begin
                out_q <= 1'b1;
              end
            end
          end
          ST_RUN: begin
            case (mode_q)
              `PIC_CODE_M0: begin
                if (gate) begin
                  count_q <= dec_val;
                  // high at terminal count and held
                  if (at_one) begin
                    out_q   <= 1'b1;
                    state_q <= ST_DONE;
                  end
                end
              end
              `PIC_CODE_M1: begin
                if (trig_q) begin
                  // A trigger arriving now stays pending
                  trig_q  <= gate_rise;
                  count_q <= reload_q;
                  out_q   <= 1'b0;
                end else begin
                  count_q <= dec_val;
                  if (at_one) begin
                    out_q   <= 1'b1;
                    state_q <= ST_DONE;
                  end
                end
              end
              `PIC_CODE_M2: begin
                if (gate) begin
                  if (at_one) begin
                    out_q   <= 1'b1;
                    count_q <= reload_q;
                  end else begin
                    count_q <= dec_val;
                    if (count_q == {{(WIDTH-2){1'b0}}, 2'b10}) begin
                      out_q <= 1'b0;
                    end
                  end
                end
              end
              `PIC_CODE_M3: begin
                if (gate) begin
                  if (at_one || count_q == {{(WIDTH-2){1'b0}}, 2'b10}) begin
                    out_q   <= half_q;
                    half_q  <= !half_q;
                    count_q <= reload_q[0] && !half_q
                               ? reload_q - {{(WIDTH-1){1'b0}}, 1'b1} : reload_q;
                  end else begin
                    count_q <= dec_val;
                  end
                end
              end
              default: begin
                if (gate || mode_q == `PIC_CODE_M5) begin
                  count_q <= dec_val;
                  if (at_one) begin
                    out_q   <= 1'b0;
                    state_q <= ST_DONE;
                  end
                end
              end
            endcase
          end
          ST_DONE: begin
            if (strobe_mode(mode_q)) begin
              out_q <= 1'b1;
            end
            if (mode_q == `PIC_CODE_M5 && trig_q) begin
              state_q <= ST_LOAD;
            end else if (mode_q == `PIC_CODE_M1 && trig_q) begin
              state_q <= ST_LOAD;
            end else begin
              count_q <= dec_val;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== rtl/pic_decrement.v
// Binary or BCD decrement by one or two, with wrap
`timescale 1ns/10ps
module pic_decrement #(
  parameter WIDTH = 16
) (
  // Operand
  input  wire [WIDTH-1:0] value,
  input  wire             bcd,
  input  wire             by_two,
  // Result
  output reg  [WIDTH-1:0] result
);
  reg [WIDTH-1:0] tmp;
  reg [3:0]       dig;
  reg             brw;
  integer         i;
  integer         k;
  always @* begin
    tmp = value;
    result = value;
    dig = 4'h0;
    brw = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      if (k == 0 || by_two) begin
        if (!bcd) begin
          tmp = tmp - {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
          brw = 1'b1;
          for (i = 0; i < WIDTH / 4; i = i + 1) begin
            dig = tmp[i*4 +: 4];
            if (brw) begin
              if (dig == 4'h0) begin
                dig = 4'h9;
              end else begin
                dig = dig - 4'h1;
                brw = 1'b0;
              end
            end
            tmp[i*4 +: 4] = dig;
          end
        end
      end
    end
    result = tmp;
  end
endmodule

// ===== rtl/pic_defines.vh
// Constants for the programmable interval counter block
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
`define PIC_ADDR_CTRL    4'h0
`define PIC_ADDR_COUNT   4'h4
`define PIC_ADDR_READ    4'h8
`define PIC_ADDR_STATUS  4'hC
`define PIC_ADDR_MSB     3
`define PIC_CODE_LSB     0
`define PIC_CODE_MSB     2
`define PIC_BCD_BIT      3
`define PIC_LEVEL_BIT    4
`define PIC_CODE_READ    3'h6
`define PIC_CODE_RESET   3'h7
`define PIC_CODE_M0      3'h0
`define PIC_CODE_M1      3'h1
`define PIC_CODE_M2      3'h2
`define PIC_CODE_M3      3'h3
`define PIC_CODE_M4      3'h4
`define PIC_CODE_M5      3'h5
`define PIC_CTRL_RST     5'h00
`define PIC_HTRANS_NSEQ  2'h2
`define PIC_HSIZE_WORD   3'h2
`endif

// ===== verification/pic_counter_bench.sv
// Self-checking bench for the interval counter channel
`timescale 1ns/10ps
`include "pic_defines.vh"
`define CHECK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module pic_counter_bench;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         cnt_clk = 1'b1;
  reg         gate = 1'b0;
  reg  [2:0]  div_q = 3'h0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        cnt_out;
  integer     bad_count = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  integer     n;
  pic_counter #(.WIDTH(16)) DUT (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(`PIC_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cnt_clk(cnt_clk),
    .gate(gate), .cnt_out(cnt_out));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Count clock of eight core cycles, plus run limit
  always @(posedge core_clk) begin
    div_q   <= div_q + 3'h1;
    cnt_clk <= div_q < 3'h4;
    cyc     <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      results();
    end
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `PIC_HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Low samples of the output over k count-clock periods
  task lows(input integer k);
    begin
      n = 0;
      repeat (k) begin
        @(posedge cnt_clk);
        @(posedge core_clk);
        n = n + (cnt_out === 1'b0);
      end
    end
  endtask
  task range(input [31:0] c, input [31:0] v, input e);
    begin
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      wr(`PIC_ADDR_CTRL, c);
      wr(`PIC_ADDR_COUNT, v);
      bus(1'b0, `PIC_ADDR_STATUS, 32'h0);
      `CHECK(rd[3], e)
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    `CHECK(cnt_out, 1'b0)
    bus(1'b0, 32'h10, 32'h0);
    `CHECK(rd, 32'h0)
    wr(`PIC_ADDR_CTRL, 32'h8 | `PIC_CODE_M0);
    wr(`PIC_ADDR_COUNT, 32'h100);
    gate <= 1'b1;
    lows(4);
    wr(`PIC_ADDR_CTRL, `PIC_CODE_READ);
    bus(1'b0, `PIC_ADDR_READ, 32'h0);
    `CHECK(rd[15:0] >= 16'h95 && rd[15:0] <= 16'h99, 1'b1)
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M0);
    gate <= 1'b0;
    wr(`PIC_ADDR_COUNT, 32'h3);
    lows(8);
    `CHECK(n, 8)
    gate <= 1'b1;
    lows(6);
    lows(6);
    `CHECK(n, 0)
    wr(`PIC_ADDR_CTRL, 32'h17);
    lows(1);
    `CHECK(n, 0)
    wr(`PIC_ADDR_CTRL, `PIC_CODE_RESET);
    lows(1);
    `CHECK(n, 1)
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M2);
    wr(`PIC_ADDR_COUNT, 32'h4);
    lows(4);
    lows(16);
    `CHECK(n, 4)
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M3);
    wr(`PIC_ADDR_COUNT, 32'h4);
    bus(1'b0, 32'h10, 32'h0);
    `CHECK(rd, 32'h0)
    lows(4);
    lows(16);
    `CHECK(n, 8)
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M4);
    wr(`PIC_ADDR_COUNT, 32'h3);
    lows(12);
    `CHECK(n, 1)
    gate <= 1'b0;
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M1);
    wr(`PIC_ADDR_COUNT, 32'h3);
    lows(4);
    `CHECK(n, 0)
    gate <= 1'b1;
    lows(10);
    `CHECK(n, 3)
    gate <= 1'b0;
    wr(`PIC_ADDR_CTRL, `PIC_CODE_M5);
    wr(`PIC_ADDR_COUNT, 32'h3);
    lows(6);
    `CHECK(n, 0)
    gate <= 1'b1;
    lows(10);
    `CHECK(n, 1)
    range(`PIC_CODE_M2, 32'h1, 1'b1);
    range(32'h8, 32'hA, 1'b1);
    range(32'h8, 32'h9999, 1'b0);
    results();
  end
endmodule

// ===== verification/pic_counter_sva.sv
// Assertion checker for the interval counter channel
`timescale 1ns/10ps
`include "pic_defines.vh"
module pic_counter_chk #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Pins
  input wire        cnt_clk,
  input wire        gate,
  input wire        cnt_out
);
  reg        wr_q;
  reg  [3:0] adr_q;
  reg  [2:0] mode_q;
  reg        cclk_q;
  reg  [1:0] lowf_q;
  wire       ctrl_wr = wr_q && adr_q == `PIC_ADDR_CTRL;
  wire [2:0] code    = hwdata[2:0];
  wire       lvl     = hwdata[4];
  always @(posedge core_clk) begin
    wr_q   <= hsel && hready && htrans == 2'h2 && hwrite && !rst;
    adr_q  <= haddr[3:0];
    cclk_q <= cnt_clk;
    if (rst)
      mode_q <= 3'h0;
    else if (ctrl_wr && code < 3'h6)
      mode_q <= code;
    // Falling count-clock edges seen while the output is low
    if (rst || cnt_out || ctrl_wr)
      lowf_q <= 2'h0;
    else if (cclk_q && !cnt_clk && lowf_q != 2'h3)
      lowf_q <= lowf_q + 2'h1;
  end
  chk_ready_high: assert property (@(posedge core_clk) hreadyout)
    else $error("bus slave not ready");
  chk_resp_okay: assert property (@(posedge core_clk) !hresp)
    else $error("bus response not okay");
  chk_reset_idle: assert property (@(posedge core_clk) rst |=> !cnt_out && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  chk_low_set: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_wr && (code == 3'h0 || code == 3'h7 && !lvl) |=> !cnt_out)
    else $error("output not driven low");
  chk_high_set: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_wr && (code == 3'h4 || code == 3'h5 || code == 3'h7 && lvl) |=> cnt_out)
    else $error("output not driven high");
  chk_tc_hold: assert property (@(posedge core_clk) disable iff (rst)
    mode_q == 3'h0 && cnt_out && !(ctrl_wr && code != 3'h6) |=> cnt_out)
    else $error("terminal count output not held");
  chk_gate_pause: assert property (@(posedge core_clk) disable iff (rst)
    mode_q == 3'h0 && !gate && !$past(gate) && !cnt_out && !ctrl_wr |=> !cnt_out)
    else $error("counting while gate low");
  chk_strobe_width: assert property (@(posedge core_clk) disable iff (rst)
    (mode_q == 3'h2 || mode_q == 3'h4 || mode_q == 3'h5) |-> lowf_q < 2'h2)
    else $error("low pulse longer than one clock");
endmodule
bind pic_counter pic_counter_chk #(.WIDTH(WIDTH)) u_chk (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cnt_clk(cnt_clk), .gate(gate), .cnt_out(cnt_out));
